// ==== slave_comm_pkg.sv ====
// package with state codes, request codes and timing for the slave communication state gating
package slave_comm_pkg;

    // ----------------------------------------------------------------
    // slave state machine encoding
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_INIT = 2'h0,
        ST_PRE_OPERATIONAL = 2'h1,
        ST_SAFE_OPERATIONAL = 2'h2,
        ST_OPERATIONAL = 2'h3
    } slave_state_t;

    // ----------------------------------------------------------------
    // request results and defaults
    // ----------------------------------------------------------------
    localparam logic [1:0] RESULT_NONE = 2'h0;
    localparam logic [1:0] RESULT_ACCEPT = 2'h1;
    localparam logic [1:0] RESULT_REFUSE = 2'h2;
    localparam int INIT_DONE_CYCLES = 4;
    localparam int DATA_WIDTH = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int INDEX_WIDTH = 16;
    localparam int SENSOR_COUNT_WIDTH = 4;

endpackage

// ==== pdo_fifo.sv ====
// synchronous fifo with valid and ready on both sides
module pdo_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic flush_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] count;
    } fifo_state_t;

    logic [WIDTH-1:0] mem [DEPTH];
    fifo_state_t s_r;
    fifo_state_t s_nxt;
    logic do_wr;
    logic do_rd;

    // full compare at the counter's own width so a depth of 2**AW is not lost
    assign wr_ready_out = (s_r.count != (AW+1)'(DEPTH)) && !flush_in;
    assign rd_valid_out = (s_r.count != '0);
    assign rd_data_out = mem[s_r.rp];
    assign do_wr = wr_valid_in && wr_ready_out;
    assign do_rd = rd_valid_out && rd_ready_in;

    always_comb begin
        s_nxt = s_r;
        if (flush_in) begin
            s_nxt = '0;
        end else begin
            if (do_wr) begin
                s_nxt.wp = s_r.wp + 1'b1;
            end
            if (do_rd) begin
                s_nxt.rp = s_r.rp + 1'b1;
            end
            s_nxt.count = s_r.count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
        if (do_wr) begin
            mem[s_r.wp] <= wr_data_in;
        end
    end

endmodule

// ==== slave_comm_state_gating.sv ====
// slave communication state machine gating mailbox and cyclic process data

// Notes on behaviour
// R1 - state changes only on a master request; never on its own
// R2 - initialising: mailbox refused, no cyclic transmit, no cyclic receive
// R3 - pre-operational: mailbox served, cyclic data neither sent nor accepted
// R4 - pre-operational is entered only once initialisation has completed
// R5 - safe-operational: mailbox served, inputs sent, received outputs ignored
// R6 - operational: mailbox served, cyclic data sent and accepted
// R7 - request to operational refused while no sensor amplifier is present
// R8 - mailbox reads and writes any dictionary entry, event driven
// R9 - cyclic data sent only on the regular period tick, mappable objects only
// R10 - after reset start initialising with all communication disabled
module slave_comm_state_gating #(
    parameter int DATA_WIDTH = slave_comm_pkg::DATA_WIDTH,
    parameter int FIFO_DEPTH = slave_comm_pkg::FIFO_DEPTH,
    parameter int INIT_CYCLES = slave_comm_pkg::INIT_DONE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    // master state request
    input wire logic state_req_valid_in,
    input wire logic [1:0] state_req_in,
    output logic [1:0] state_out,
    output logic [1:0] req_result_out,
    // sensor side
    input wire logic [slave_comm_pkg::SENSOR_COUNT_WIDTH-1:0] sensor_count_in,
    // mailbox access
    input wire logic mbx_valid_in,
    input wire logic mbx_write_in,
    input wire logic [slave_comm_pkg::INDEX_WIDTH-1:0] mbx_index_in,
    input wire logic [DATA_WIDTH-1:0] mbx_wdata_in,
    output logic mbx_done_out,
    output logic mbx_refused_out,
    output logic mbx_write_out,
    output logic [slave_comm_pkg::INDEX_WIDTH-1:0] mbx_index_out,
    output logic [DATA_WIDTH-1:0] mbx_data_out,
    input wire logic [DATA_WIDTH-1:0] dict_rdata_in,
    // cyclic transmit: local inputs into fifo, drained on the cycle tick
    input wire logic [DATA_WIDTH-1:0] tx_data_in,
    input wire logic tx_valid_in,
    input wire logic tx_mappable_in,
    output logic tx_ready_out,
    input wire logic cycle_tick_in,
    output logic [DATA_WIDTH-1:0] pdo_tx_data_out,
    output logic pdo_tx_valid_out,
    // cyclic receive from master
    input wire logic [DATA_WIDTH-1:0] pdo_rx_data_in,
    input wire logic pdo_rx_valid_in,
    output logic [DATA_WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    output logic [2:0] gate_out
);

    // ----------------------------------------------------------------
    // state record
    // ----------------------------------------------------------------
    typedef struct packed {
        slave_comm_pkg::slave_state_t st;
        logic init_done;
        logic [7:0] init_cnt;
        logic [1:0] result;
        logic mbx_done;
        logic mbx_refused;
        logic mbx_write;
        logic [slave_comm_pkg::INDEX_WIDTH-1:0] mbx_index;
        logic [DATA_WIDTH-1:0] mbx_data;
        logic [DATA_WIDTH-1:0] tx_data;
        logic tx_valid;
        logic [DATA_WIDTH-1:0] out_data;
        logic out_valid;
        logic tx_ready;
        logic [2:0] gate;
    } gate_state_t;

    gate_state_t s_r;
    gate_state_t s_nxt;
    logic mbx_ok;
    logic tx_ok;
    logic rx_ok;
    logic [DATA_WIDTH-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic fifo_wr_ready;
    slave_comm_pkg::slave_state_t req_st;

    assign req_st = slave_comm_pkg::slave_state_t'(state_req_in);
    assign mbx_ok = (s_r.st != slave_comm_pkg::ST_INIT); // see R2 see R3
    assign tx_ok = (s_r.st == slave_comm_pkg::ST_SAFE_OPERATIONAL)
        || (s_r.st == slave_comm_pkg::ST_OPERATIONAL); // see R5
    assign rx_ok = (s_r.st == slave_comm_pkg::ST_OPERATIONAL); // see R6
    assign fifo_pop = tx_ok && cycle_tick_in && fifo_valid; // see R9

    // ----------------------------------------------------------------
    // transmit buffer
    // ----------------------------------------------------------------
    pdo_fifo #(
        .WIDTH(DATA_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .flush_in(!tx_ok),
        .wr_data_in(tx_data_in),
        .wr_valid_in(tx_valid_in && tx_mappable_in), // see R9
        .wr_ready_out(fifo_wr_ready),
        .rd_data_out(fifo_data),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(fifo_pop)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.result = slave_comm_pkg::RESULT_NONE;
        s_nxt.mbx_done = 1'b0;
        s_nxt.mbx_refused = 1'b0;
        s_nxt.tx_valid = 1'b0;
        s_nxt.out_valid = 1'b0;
        s_nxt.tx_ready = fifo_wr_ready;
        if (!s_r.init_done) begin
            if (s_r.init_cnt == 8'(INIT_CYCLES - 1)) begin
                s_nxt.init_done = 1'b1;
            end else begin
                s_nxt.init_cnt = s_r.init_cnt + 8'h01;
            end
        end
        if (state_req_valid_in) begin // see R1
            s_nxt.result = slave_comm_pkg::RESULT_ACCEPT;
            case (req_st)
                slave_comm_pkg::ST_INIT: begin
                    s_nxt.st = slave_comm_pkg::ST_INIT;
                end
                slave_comm_pkg::ST_PRE_OPERATIONAL: begin
                    if (s_r.init_done) begin // see R4
                        s_nxt.st = slave_comm_pkg::ST_PRE_OPERATIONAL;
                    end else begin
                        s_nxt.result = slave_comm_pkg::RESULT_REFUSE;
                    end
                end
                slave_comm_pkg::ST_SAFE_OPERATIONAL: begin
                    if (s_r.st != slave_comm_pkg::ST_INIT) begin
                        s_nxt.st = slave_comm_pkg::ST_SAFE_OPERATIONAL;
                    end else begin
                        s_nxt.result = slave_comm_pkg::RESULT_REFUSE;
                    end
                end
                slave_comm_pkg::ST_OPERATIONAL: begin
                    if (s_r.st == slave_comm_pkg::ST_INIT || s_r.st == slave_comm_pkg::ST_PRE_OPERATIONAL
                        || sensor_count_in == '0) begin // see R7
                        s_nxt.result = slave_comm_pkg::RESULT_REFUSE;
                    end else begin
                        s_nxt.st = slave_comm_pkg::ST_OPERATIONAL;
                    end
                end
                default: begin
                    s_nxt.result = slave_comm_pkg::RESULT_REFUSE;
                end
            endcase
        end
        // gate flags follow the next state so they line up with state_out
        s_nxt.gate = {s_nxt.st == slave_comm_pkg::ST_OPERATIONAL,
            s_nxt.st == slave_comm_pkg::ST_SAFE_OPERATIONAL || s_nxt.st == slave_comm_pkg::ST_OPERATIONAL,
            s_nxt.st != slave_comm_pkg::ST_INIT};
        if (mbx_valid_in) begin // see R8
            s_nxt.mbx_refused = !mbx_ok; // see R2
            s_nxt.mbx_done = mbx_ok; // see R3
            s_nxt.mbx_write = mbx_write_in;
            s_nxt.mbx_index = mbx_index_in;
            s_nxt.mbx_data = mbx_write_in ? mbx_wdata_in : dict_rdata_in;
        end
        if (fifo_pop) begin
            s_nxt.tx_valid = 1'b1; // see R5 see R6
            s_nxt.tx_data = fifo_data;
        end
        if (pdo_rx_valid_in && rx_ok) begin // see R5 see R6
            s_nxt.out_valid = 1'b1;
            s_nxt.out_data = pdo_rx_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_r <= '0; // see R10
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign state_out = s_r.st;
    assign req_result_out = s_r.result;
    assign mbx_done_out = s_r.mbx_done;
    assign mbx_refused_out = s_r.mbx_refused;
    assign mbx_write_out = s_r.mbx_write;
    assign mbx_index_out = s_r.mbx_index;
    assign mbx_data_out = s_r.mbx_data;
    assign tx_ready_out = s_r.tx_ready;
    assign pdo_tx_data_out = s_r.tx_data;
    assign pdo_tx_valid_out = s_r.tx_valid;
    assign out_data_out = s_r.out_data;
    assign out_valid_out = s_r.out_valid;
    assign gate_out = s_r.gate;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_no_self_change: assert property (@(posedge clk_in) disable iff (rst_in) // see R1
        $changed(state_out) && !$past(rst_in) |-> $past(state_req_valid_in))
        else $error("state changed without request");
    a_init_mbx_refused: assert property (@(posedge clk_in) disable iff (rst_in) // see R2
        mbx_valid_in && state_out == 2'h0 |=> mbx_refused_out && !mbx_done_out)
        else $error("mailbox served while initialising");
    a_preop_mbx_served: assert property (@(posedge clk_in) disable iff (rst_in) // see R3
        mbx_valid_in && state_out == 2'h1 |=> mbx_done_out)
        else $error("mailbox not served in pre-operational");
    a_preop_after_init: assert property (@(posedge clk_in) disable iff (rst_in) // see R4
        state_out == 2'h1 |-> s_r.init_done)
        else $error("pre-operational before initialisation done");
    a_safeop_rx_ignored: assert property (@(posedge clk_in) disable iff (rst_in) // see R5
        out_valid_out |-> $past(state_out) == 2'h3 && $past(pdo_rx_valid_in))
        else $error("output data accepted outside operational");
    a_tx_only_running: assert property (@(posedge clk_in) disable iff (rst_in) // see R6
        pdo_tx_valid_out |-> $past(state_out) >= 2'h2 && $past(cycle_tick_in))
        else $error("cyclic transmit outside allowed states or tick");
    a_op_needs_sensor: assert property (@(posedge clk_in) disable iff (rst_in) // see R7
        state_req_valid_in && state_req_in == 2'h3 && sensor_count_in == '0 && state_out != 2'h3
        |=> state_out != 2'h3 && req_result_out == 2'h2)
        else $error("operational entered without amplifier");
    a_reset_init: assert property (@(posedge clk_in) // see R10
        rst_in |=> state_out == 2'h0 && !pdo_tx_valid_out && !out_valid_out)
        else $error("not initialising after reset");

endmodule

// ==== master_model.sv ====
// fieldbus master model: state requests, mailbox accesses, cycle ticks and output data
module master_model (
    input wire logic clk_in,
    output logic req_v_out,
    output logic [1:0] req_s_out,
    output logic mbx_v_out,
    output logic mbx_w_out,
    output logic [15:0] mbx_i_out,
    output logic [15:0] mbx_d_out,
    output logic tick_out,
    output logic rx_v_out,
    output logic [15:0] rx_d_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {req_v_out, req_s_out, mbx_v_out, mbx_w_out, tick_out, rx_v_out} = '0;
        {mbx_i_out, mbx_d_out, rx_d_out} = '0;
    end
    // every transition is commanded here, one request per call
    task automatic req(input logic [1:0] s);
        @(posedge clk_in);
        #1;
        req_v_out = 1'b1;
        req_s_out = s;
        @(posedge clk_in);
        #1;
        req_v_out = 1'b0;
        req_s_out = ~s;
    endtask
    // mailbox access is sent on demand, never on a fixed period
    task automatic mbx(input logic w, input logic [15:0] i, input logic [15:0] d);
        @(posedge clk_in);
        #1;
        {mbx_v_out, mbx_w_out, mbx_i_out, mbx_d_out} = {1'b1, w, i, d};
        @(posedge clk_in);
        #1;
        {mbx_v_out, mbx_w_out, mbx_i_out, mbx_d_out} = {1'b0, ~w, ~i, ~d};
    endtask
    task automatic tick();
        @(posedge clk_in);
        #1;
        tick_out = 1'b1;
        @(posedge clk_in);
        #1;
        tick_out = 1'b0;
    endtask
    task automatic rx(input logic [15:0] d);
        @(posedge clk_in);
        #1;
        {rx_v_out, rx_d_out} = {1'b1, d};
        @(posedge clk_in);
        #1;
        {rx_v_out, rx_d_out} = {1'b0, ~d};
    endtask
endmodule

// ==== slave_comm_state_gating_bench.sv ====
// self-checking bench for the slave communication state gating block
module slave_comm_state_gating_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_v, mbx_v, mbx_w, tick, rx_v, tx_valid_in = 1'b0, tx_mappable_in = 1'b0;
    logic [1:0] req_s, state_out, req_result_out;
    logic [2:0] gate_out;
    logic [3:0] sensor_count_in = 4'h0;
    logic [15:0] mbx_i, mbx_d, rx_d, dict_rdata, mbx_index_out, mbx_data_out, pdo_tx_data_out, out_data_out;
    logic [15:0] tx_data_in = 16'h0;
    logic mbx_done_out, mbx_refused_out, mbx_write_out, tx_ready_out, pdo_tx_valid_out, out_valid_out;
    int error_cnt = 0;
    int n_compared = 0;
    assign dict_rdata = mbx_i ^ 16'h5a5a;
    initial forever #50 clk_in = ~clk_in;
    slave_comm_state_gating u_dut (.clk_in(clk_in), .rst_in(rst_in), .state_req_valid_in(req_v),
        .state_req_in(req_s), .state_out(state_out), .req_result_out(req_result_out),
        .sensor_count_in(sensor_count_in), .mbx_valid_in(mbx_v), .mbx_write_in(mbx_w), .mbx_index_in(mbx_i),
        .mbx_wdata_in(mbx_d), .mbx_done_out(mbx_done_out), .mbx_refused_out(mbx_refused_out),
        .mbx_write_out(mbx_write_out), .mbx_index_out(mbx_index_out), .mbx_data_out(mbx_data_out),
        .dict_rdata_in(dict_rdata), .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in),
        .tx_mappable_in(tx_mappable_in), .tx_ready_out(tx_ready_out), .cycle_tick_in(tick),
        .pdo_tx_data_out(pdo_tx_data_out), .pdo_tx_valid_out(pdo_tx_valid_out), .pdo_rx_data_in(rx_d),
        .pdo_rx_valid_in(rx_v), .out_data_out(out_data_out), .out_valid_out(out_valid_out), .gate_out(gate_out));
    master_model u_m (.clk_in(clk_in), .req_v_out(req_v), .req_s_out(req_s), .mbx_v_out(mbx_v),
        .mbx_w_out(mbx_w), .mbx_i_out(mbx_i), .mbx_d_out(mbx_d), .tick_out(tick), .rx_v_out(rx_v),
        .rx_d_out(rx_d));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic req(input logic [1:0] s, input logic [1:0] res, input logic [1:0] st);
        u_m.req(s);
        chk(req_result_out, res);
        chk(state_out, st);
    endtask
    task automatic mbx(input logic w, input logic [15:0] i, input logic [15:0] d, input logic ok);
        u_m.mbx(w, i, d);
        chk(mbx_done_out, ok);
        chk(mbx_refused_out, !ok);
        if (ok) begin
            chk(mbx_write_out, w);
            chk(mbx_index_out, i);
            chk(mbx_data_out, w ? d : i ^ 16'h5a5a);
        end
    endtask
    task automatic rx(input logic [15:0] d, input logic ok);
        u_m.rx(d);
        chk(out_valid_out, ok);
        if (ok) chk(out_data_out, d);
    endtask
    task automatic end_sim();
        if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_init();
        chk(state_out, 2'h0);
        chk(gate_out, 3'h0);
        req(2'h1, slave_comm_pkg::RESULT_REFUSE, 2'h0);
        mbx(1'b0, 16'h1000, 16'h0, 1'b0);
        rx(16'h1234, 1'b0);
        u_m.tick();
        chk(pdo_tx_valid_out, 1'b0);
        req(2'h1, slave_comm_pkg::RESULT_ACCEPT, 2'h1);
    endtask
    task automatic t_preop();
        chk(gate_out, 3'h1);
        mbx(1'b1, 16'h6100, 16'hc0de, 1'b1);
        mbx(1'b0, 16'h3001, 16'h0, 1'b1);
        rx(16'h4321, 1'b0);
        u_m.tick();
        chk(pdo_tx_valid_out, 1'b0);
        repeat (5) @(posedge clk_in);
        #1;
        chk(state_out, 2'h1);
    endtask
    task automatic t_safeop();
        req(2'h2, slave_comm_pkg::RESULT_ACCEPT, 2'h2);
        chk(gate_out, 3'h3);
        rx(16'h5555, 1'b0);
        req(2'h3, slave_comm_pkg::RESULT_REFUSE, 2'h2);
        @(posedge clk_in);
        #1;
        tx_valid_in = 1'b1;
        for (int i = 0; i < 18; i++) begin
            tx_data_in = 16'ha000 + 16'(i);
            tx_mappable_in = (i != 3);
            @(posedge clk_in);
            #1;
        end
        tx_valid_in = 1'b0;
        @(posedge clk_in);
        #1;
        chk(tx_ready_out, 1'b0);
        for (int j = 0; j < 16; j++) begin
            u_m.tick();
            chk(pdo_tx_valid_out, 1'b1);
            chk(pdo_tx_data_out, 16'ha000 + 16'(j < 3 ? j : j + 1));
        end
        u_m.tick();
        chk(pdo_tx_valid_out, 1'b0);
    endtask
    task automatic t_op();
        sensor_count_in = 4'h2;
        req(2'h3, slave_comm_pkg::RESULT_ACCEPT, 2'h3);
        chk(gate_out, 3'h7);
        mbx(1'b0, 16'h4001, 16'h0, 1'b1);
        rx(16'h9abc, 1'b1);
        sensor_count_in = 4'h0;
        @(posedge clk_in);
        #1;
        chk(state_out, 2'h3);
        req(2'h3, slave_comm_pkg::RESULT_REFUSE, 2'h3);
        req(2'h0, slave_comm_pkg::RESULT_ACCEPT, 2'h0);
        chk(gate_out, 3'h0);
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        t_init();
        t_preop();
        t_safeop();
        t_op();
        end_sim();
    end
    initial begin
        #(3000 * 100);
        error_cnt++;
        end_sim();
    end
endmodule
